/* File: smbm_defines.svh */
// smbm_defines.svh - constants of the smbus block memory access logic
`ifndef SMBM_DEFINES_SVH
`define SMBM_DEFINES_SVH
`define SMBM_SLV_ADDR 7'h2A
`define SMBM_CMD_BLK_WR 8'hFC
`define SMBM_CMD_BLK_RD 8'hFD
`define SMBM_BLK_CNT 8'h20
`define SMBM_BLK_MAX 6'h20
`define SMBM_RAM_TOP 8'hDF
`define SMBM_EE_HI_MIN 8'hF8
`define SMBM_EE_HI_MAX 8'hFB
`define SMBM_CRC_POLY 8'h07
`define SMBM_CLK_MHZ 50
`define SMBM_EE_PROG_US 250
`define SMBM_EE_PROG_CYC (`SMBM_EE_PROG_US * `SMBM_CLK_MHZ)
`define SMBM_BUF_DEPTH 2
`endif

/* File: smbm_pkg.sv */
// smbm_pkg.sv - types of the smbus block memory access logic
package smbm_pkg;
   typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_HOLD, ST_TX, ST_MACK} smbm_st_t;
   typedef struct packed {
      logic s1_scl;
      logic s2_scl;
      logic p_scl;
      logic s1_sda;
      logic s2_sda;
      logic p_sda;
      smbm_st_t st;
      logic [3:0] bcnt;
      logic [7:0] sh;
      logic [5:0] idx;
      logic [5:0] tidx;
      logic rd_mode;
      logic [7:0] cmd;
      logic [5:0] cnt;
      logic [15:0] ptr;
      logic [7:0] crc;
      logic [15:0] wa;
      logic [7:0] wd;
      logic scl_oe;
      logic sda_oe;
      logic drv_lvl;
      logic wr_vld;
      logic [15:0] wr_addr;
      logic [7:0] wr_data;
      logic [15:0] ee_tmr;
      logic pec_err;
   } smbm_state_t;
endpackage

/* File: smbm_wbuf.sv */
// smbm_wbuf.sv - small fifo holding memory writes between bus and memory port
`timescale 1ns/1ps
`include "smbm_defines.svh"
module smbm_wbuf #(
   parameter int W = 24,
   parameter int DEPTH = `SMBM_BUF_DEPTH
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] rp;
      logic [AW-1:0] wp;
      logic [AW:0] cnt;
   } smbm_buf_t;
   smbm_buf_t q_ff, nxt_q;
   logic do_wr, do_rd;

   assign in_ready = (q_ff.cnt != (AW+1)'(DEPTH));
   assign out_valid = (q_ff.cnt != '0);
   assign out_data = q_ff.mem[q_ff.rp];

   always_comb begin
      nxt_q = q_ff;
      do_wr = in_valid && in_ready;
      do_rd = out_valid && out_ready;
      if (do_wr) begin
         nxt_q.mem[q_ff.wp] = in_data;
         nxt_q.wp = (q_ff.wp == AW'(DEPTH-1)) ? '0 : q_ff.wp + 1'b1;
      end
      if (do_rd) begin
         nxt_q.rp = (q_ff.rp == AW'(DEPTH-1)) ? '0 : q_ff.rp + 1'b1;
      end
      if (do_wr && !do_rd) begin
         nxt_q.cnt = q_ff.cnt + 1'b1;
      end else if (do_rd && !do_wr) begin
         nxt_q.cnt = q_ff.cnt - 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         q_ff <= '0;
      end else begin
         q_ff <= nxt_q;
      end
   end
endmodule // smbm_wbuf

/* File: smbm_slave.sv */
// smbm_slave.sv - smbus slave for block access to ram and eeprom
`timescale 1ns/1ps
`include "smbm_defines.svh"
module smbm_slave #(
   parameter logic [6:0] SLV_ADDR = `SMBM_SLV_ADDR,
   parameter int EE_PROG_CYC = `SMBM_EE_PROG_CYC
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // smbus pins
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // memory read port
   output logic [15:0] rd_addr,
   input wire logic [7:0] rd_data,
   // memory write port
   output logic wr_valid,
   input wire logic wr_ready,
   output logic [15:0] wr_addr,
   output logic [7:0] wr_data,
   // status
   output logic pec_err
);
   smbm_pkg::smbm_state_t q, nxt_q;
   logic rise, fall, start, stop, done, ld, do_wr, is_ee, is_ram, is_blk;
   logic buf_in_ready, buf_push, buf_out_valid, buf_out_ready;
   logic [23:0] buf_in, buf_out;
   logic [7:0] b, tb;

   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] r;
      logic fb;
      r = c;
      for (int i = 7; i >= 0; i--) begin
         fb = r[7] ^ d[i];
         r = {r[6:0], 1'b0};
         if (fb) begin
            r = r ^ `SMBM_CRC_POLY;
         end
      end
      return r;
   endfunction

   smbm_wbuf #(.W(24), .DEPTH(`SMBM_BUF_DEPTH)) u_wbuf (
      .core_clk(core_clk),
      .nrst(nrst),
      .in_valid(buf_push),
      .in_ready(buf_in_ready),
      .in_data(buf_in),
      .out_valid(buf_out_valid),
      .out_ready(buf_out_ready),
      .out_data(buf_out)
   );

   // ----------------------------------------
   // bus events
   // ----------------------------------------
   assign rise = q.s2_scl && !q.p_scl;
   assign fall = !q.s2_scl && q.p_scl;
   assign start = q.s2_scl && q.p_scl && q.p_sda && !q.s2_sda;
   assign stop = q.s2_scl && q.p_scl && !q.p_sda && q.s2_sda;
   assign done = (q.st == smbm_pkg::ST_RX) && fall && (q.bcnt == 4'h8);
   assign is_ee = (q.cmd >= `SMBM_EE_HI_MIN) && (q.cmd <= `SMBM_EE_HI_MAX);
   assign is_ram = (q.cmd <= `SMBM_RAM_TOP);
   assign is_blk = (q.cmd == `SMBM_CMD_BLK_RD);
   // the timer gates draining, so a slow eeprom backs up into the fifo and then onto scl
   assign buf_out_ready = !q.wr_vld && (q.ee_tmr == 16'h0000);

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      nxt_q = q;
      do_wr = 1'b0;
      ld = 1'b0;
      buf_push = 1'b0;
      buf_in = {q.wa, q.wd};
      b = q.sh;
      tb = q.crc;
      nxt_q.s1_scl = scl_i;
      nxt_q.s2_scl = q.s1_scl;
      nxt_q.p_scl = q.s2_scl;
      nxt_q.s1_sda = sda_i;
      nxt_q.s2_sda = q.s1_sda;
      nxt_q.p_sda = q.s2_sda;
      if (start) begin
         // a fresh transaction forgets the old command, a repeated start keeps it
         if (q.st == smbm_pkg::ST_IDLE) begin
            nxt_q.crc = 8'h00;
            nxt_q.cmd = 8'hFF;
         end
         nxt_q.st = smbm_pkg::ST_RX;
         nxt_q.bcnt = 4'h0;
         nxt_q.idx = 6'h00;
         nxt_q.sda_oe = 1'b0;
         nxt_q.scl_oe = 1'b0;
      end else if (stop) begin
         nxt_q.st = smbm_pkg::ST_IDLE;
         nxt_q.sda_oe = 1'b0;
         nxt_q.scl_oe = 1'b0;
      end else begin
         case (q.st)
            smbm_pkg::ST_RX: begin
               if (rise) begin
                  nxt_q.sh = {q.sh[6:0], q.s2_sda};
                  nxt_q.bcnt = q.bcnt + 4'h1;
               end
               if (done) begin
                  nxt_q.crc = crc8(q.crc, b);
                  nxt_q.wa = q.ptr;
                  nxt_q.wd = b;
                  nxt_q.idx = (q.idx == 6'h3F) ? q.idx : q.idx + 6'h01;
                  if (q.idx == 6'h00) begin
                     nxt_q.rd_mode = b[0];
                     nxt_q.tidx = 6'h00;
                  end else if (q.idx == 6'h01) begin
                     nxt_q.cmd = b;
                     if (b <= `SMBM_RAM_TOP) begin
                        nxt_q.ptr = {8'h00, b};
                     end
                  end else if (q.idx == 6'h02) begin
                     if (q.cmd == `SMBM_CMD_BLK_WR) begin
                        nxt_q.cnt = (b > 8'h20) ? `SMBM_BLK_MAX : b[5:0];
                     end else if (is_ee) begin
                        nxt_q.ptr = {q.cmd, b};
                     end else if (is_ram) begin
                        do_wr = 1'b1;
                     end
                  end else if (q.cmd == `SMBM_CMD_BLK_WR && (q.idx - 6'h03) < q.cnt) begin
                     do_wr = 1'b1;
                     nxt_q.ptr = q.ptr + 16'h0001;
                  end else if (is_ee && q.idx == 6'h03) begin
                     do_wr = 1'b1;
                  end else if ((q.cmd == `SMBM_CMD_BLK_WR && (q.idx - 6'h03) == q.cnt)
                               || (is_ee && q.idx == 6'h04) || (is_ram && q.idx == 6'h03)) begin
                     nxt_q.pec_err = (b != q.crc);
                  end
                  if (q.idx == 6'h00 && b[7:1] != SLV_ADDR) begin
                     nxt_q.st = smbm_pkg::ST_IDLE;
                  end else if (do_wr && !buf_in_ready) begin
                     nxt_q.st = smbm_pkg::ST_HOLD;
                     nxt_q.scl_oe = 1'b1;
                  end else begin
                     buf_push = do_wr;
                     buf_in = {q.ptr, b};
                     nxt_q.st = smbm_pkg::ST_ACK;
                     nxt_q.sda_oe = 1'b1;
                  end
               end
            end
            smbm_pkg::ST_HOLD: begin
               if (buf_in_ready) begin
                  buf_push = 1'b1;
                  nxt_q.scl_oe = 1'b0;
                  nxt_q.sda_oe = 1'b1;
                  nxt_q.st = smbm_pkg::ST_ACK;
               end
            end
            smbm_pkg::ST_ACK: begin
               if (fall) begin
                  nxt_q.sda_oe = 1'b0;
                  nxt_q.bcnt = 4'h0;
                  nxt_q.st = smbm_pkg::ST_RX;
                  ld = q.rd_mode;
               end
            end
            smbm_pkg::ST_TX: begin
               if (fall) begin
                  if (q.bcnt == 4'h8) begin
                     nxt_q.sda_oe = 1'b0;
                     nxt_q.st = smbm_pkg::ST_MACK;
                  end else begin
                     nxt_q.sh = {q.sh[6:0], 1'b0};
                     nxt_q.sda_oe = !q.sh[6];
                     nxt_q.bcnt = q.bcnt + 4'h1;
                  end
               end
            end
            smbm_pkg::ST_MACK: begin
               if (rise && q.s2_sda) begin
                  nxt_q.st = smbm_pkg::ST_IDLE;
               end else if (fall) begin
                  ld = 1'b1;
               end
            end
            default: begin
               nxt_q.sda_oe = 1'b0;
               nxt_q.scl_oe = 1'b0;
            end
         endcase
      end
      // byte to send: count (block read only), then data, then the check byte
      if (ld) begin
         if (is_blk && q.tidx == 6'h00) begin
            tb = `SMBM_BLK_CNT;
         end else if (q.tidx < (is_blk ? 6'h21 : 6'h01)) begin
            tb = rd_data;
            if (is_blk) begin
               nxt_q.ptr = q.ptr + 16'h0001;
            end
         end else begin
            tb = q.crc;
         end
         nxt_q.crc = crc8(q.crc, tb);
         nxt_q.sh = tb;
         nxt_q.sda_oe = !tb[7];
         nxt_q.bcnt = 4'h1;
         nxt_q.tidx = (q.tidx == 6'h3F) ? q.tidx : q.tidx + 6'h01;
         nxt_q.st = smbm_pkg::ST_TX;
      end
      // ----------------------------------------
      // memory write drain
      // ----------------------------------------
      if (q.wr_vld && wr_ready) begin
         nxt_q.wr_vld = 1'b0;
      end
      if (q.ee_tmr != 16'h0000) begin
         nxt_q.ee_tmr = q.ee_tmr - 16'h0001;
      end
      if (buf_out_valid && buf_out_ready) begin
         nxt_q.wr_vld = 1'b1;
         nxt_q.wr_addr = buf_out[23:8];
         nxt_q.wr_data = buf_out[7:0];
         if (buf_out[23:16] >= `SMBM_EE_HI_MIN) begin
            nxt_q.ee_tmr = 16'(EE_PROG_CYC);
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         q <= '{st: smbm_pkg::ST_IDLE, s1_scl: 1'b1, s2_scl: 1'b1, p_scl: 1'b1,
                s1_sda: 1'b1, s2_sda: 1'b1, p_sda: 1'b1, default: '0};
      end else begin
         q <= nxt_q;
      end
   end

   assign scl_o = q.drv_lvl;
   assign sda_o = q.drv_lvl;
   assign scl_oe = q.scl_oe;
   assign sda_oe = q.sda_oe;
   assign rd_addr = q.ptr;
   assign wr_valid = q.wr_vld;
   assign wr_addr = q.wr_addr;
   assign wr_data = q.wr_data;
   assign pec_err = q.pec_err;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   a_addr_mismatch: assert property (done && q.idx == 6'h00 && q.sh[7:1] != SLV_ADDR
      |=> q.st == smbm_pkg::ST_IDLE && !q.sda_oe) else $error("foreign address acked");
   a_ack_driven: assert property (q.st == smbm_pkg::ST_ACK |-> q.sda_oe)
      else $error("ack slot not driven low");
   a_stretch_only: assert property (q.scl_oe == (q.st == smbm_pkg::ST_HOLD))
      else $error("scl held outside write stall");
   a_prog_gap: assert property (q.ee_tmr != 16'h0000 |-> !buf_out_ready)
      else $error("write issued during eeprom programming");
   a_count_sent: assert property (ld && is_blk && q.tidx == 6'h00
      |=> q.sh == 8'h20 && q.st == smbm_pkg::ST_TX) else $error("wrong block count");
   a_pec_sent: assert property (ld && is_blk && q.tidx == 6'h21
      |=> q.sh == $past(q.crc)) else $error("check byte not crc");
   a_count_clip: assert property (done && q.idx == 6'h02 && q.cmd == `SMBM_CMD_BLK_WR
      |=> q.cnt <= 6'h20) else $error("byte count above 32");
   a_ptr_step: assert property (done && q.cmd == `SMBM_CMD_BLK_WR && q.idx >= 6'h03
      && (q.idx - 6'h03) < q.cnt |=> q.ptr == $past(q.ptr) + 16'h0001) else $error("no advance");
   a_ee_addr: assert property (done && q.idx == 6'h02 && is_ee
      |=> q.ptr == {$past(q.cmd), $past(q.sh)}) else $error("eeprom address not taken");
   a_ram_addr: assert property (done && q.idx == 6'h01 && q.sh <= `SMBM_RAM_TOP
      |=> q.ptr == {8'h00, $past(q.sh)}) else $error("ram address not taken");

   c_block_read: cover property (ld && is_blk && q.tidx == 6'h21);
   c_stall: cover property (q.st == smbm_pkg::ST_HOLD ##1 q.st == smbm_pkg::ST_ACK);
   c_pec_bad: cover property ($rose(q.pec_err));
endmodule // smbm_slave

/* File: smbm_host.sv */
// smbm_host.sv - behavioural smbus host driving the link for the bench
`timescale 1ns/1ps
module smbm_host (
   // clock
   input wire logic core_clk,
   // bus
   input wire logic scl,
   input wire logic sda,
   output logic scl_oe,
   output logic sda_oe,
   // status
   output logic tmo
);
   // ---------------------------------
   // bit timing, 4 cycles a phase
   // ---------------------------------
   initial begin
      scl_oe = 1'b0;
      sda_oe = 1'b0;
      tmo = 1'b0;
   end
   task automatic ph();
      repeat (4) @(posedge core_clk);
   endtask
   // release scl, then wait out any stretch by the device
   task automatic rise();
      int k;
      k = 0;
      scl_oe <= 1'b0;
      @(posedge core_clk);
      while (scl !== 1'b1 && k < 2000) begin
         @(posedge core_clk);
         k++;
      end
      if (k >= 2000) tmo <= 1'b1;
      ph();
   endtask
   // sda moves one cycle after scl falls so no false start is seen
   task automatic bit_io(input logic b, output logic r);
      @(posedge core_clk);
      sda_oe <= ~b;
      ph();
      rise();
      r = sda;
      scl_oe <= 1'b1;
   endtask
   task automatic start();
      @(posedge core_clk);
      sda_oe <= 1'b0;
      ph();
      rise();
      sda_oe <= 1'b1;
      ph();
      scl_oe <= 1'b1;
   endtask
   task automatic stop();
      @(posedge core_clk);
      sda_oe <= 1'b1;
      ph();
      rise();
      sda_oe <= 1'b0;
      ph();
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   task automatic rbyte(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(~ack, r);
   endtask
endmodule // smbm_host

/* File: smbus_block_memory_access_tb_top.sv */
// smbus_block_memory_access_tb_top.sv - self-checking bench of the smbus memory slave
`timescale 1ns/1ps
`include "smbm_defines.svh"
module smbus_block_memory_access_tb_top;
   // short programming time keeps the run small
   localparam int EEC = 300;
   localparam logic [7:0] AW = {`SMBM_SLV_ADDR, 1'b0};
   localparam logic [7:0] AR = {`SMBM_SLV_ADDR, 1'b1};
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic scl, sda, s_oe, s_o, d_oe, d_o, h_scl_oe, h_sda_oe, tmo;
   logic [15:0] rd_addr, wr_addr;
   logic [7:0] rd_data = 8'h00;
   logic [7:0] wr_data, crc;
   logic wr_valid, pec_err;
   logic wr_ready = 1'b0;
   logic [7:0] mem [0:65535];
   logic [7:0] exp_mem [0:65535];
   int errors = 0;
   int tests_run = 0;
   int stretch = 0;
   int seed = 32'hd9c686a2;
   int ptr, a, s0;
   always #10 core_clk = ~core_clk;
   // open-drain wires, pulled up when released
   assign scl = ~((s_oe & ~s_o) | h_scl_oe);
   assign sda = ~((d_oe & ~d_o) | h_sda_oe);
   smbm_slave #(.EE_PROG_CYC(EEC)) dut_u (.core_clk(core_clk), .nrst(nrst), .scl_i(scl),
      .scl_o(s_o), .scl_oe(s_oe), .sda_i(sda), .sda_o(d_o), .sda_oe(d_oe),
      .rd_addr(rd_addr), .rd_data(rd_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
      .wr_addr(wr_addr), .wr_data(wr_data), .pec_err(pec_err));
   smbm_host host_u (.core_clk(core_clk), .scl(scl), .sda(sda), .scl_oe(h_scl_oe),
      .sda_oe(h_sda_oe), .tmo(tmo));
   // ---------------------------------
   // memory behind the slave
   // ---------------------------------
   always @(posedge core_clk) begin
      rd_data <= mem[rd_addr];
      wr_ready <= 1'($random(seed));
      if (wr_valid & wr_ready) mem[wr_addr] <= wr_data;
      if (s_oe) stretch <= stretch + 1;
   end
   always @(posedge tmo) begin
      errors++;
      end_sim();
   end
   // ---------------------------------
   // helpers
   // ---------------------------------
   task automatic end_sim();
      if (errors == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
      logic [7:0] r;
      r = c ^ b;
      for (int i = 0; i < 8; i++) r = r[7] ? {r[6:0], 1'b0} ^ 8'h07 : {r[6:0], 1'b0};
      return r;
   endfunction
   task automatic open_tx();
      host_u.start();
      crc = 8'h00;
   endtask
   task automatic send(input logic [7:0] b, input logic ea);
      logic k;
      host_u.wbyte(b, k);
      chk(k, ea);
      crc = crc8(crc, b);
   endtask
   task automatic recv(input logic ack, input logic [7:0] e);
      logic [7:0] d;
      host_u.rbyte(ack, d);
      chk(d, e);
      crc = crc8(crc, d);
   endtask
   // waits until the write port has stayed quiet past one programming time
   task automatic drain();
      int idle;
      idle = 0;
      for (int k = 0; k < 20000 && idle < EEC + 8; k++) begin
         @(posedge core_clk);
         idle = wr_valid ? 0 : idle + 1;
      end
      if (idle < EEC + 8) begin
         errors++;
         end_sim();
      end
   endtask
   // ---------------------------------
   // transactions
   // ---------------------------------
   task automatic set_addr(input logic [15:0] ad, input logic ee);
      open_tx();
      send(AW, 1'b1);
      send(ee ? ad[15:8] : ad[7:0], 1'b1);
      if (ee) send(ad[7:0], 1'b1);
      host_u.stop();
      ptr = ad;
   endtask
   task automatic blk_wr(input int n, input logic bad);
      logic [7:0] d;
      open_tx();
      send(AW, 1'b1);
      send(8'hFC, 1'b1);
      send(8'(n), 1'b1);
      for (int i = 0; i < n; i++) begin
         d = 8'($random(seed));
         exp_mem[16'(ptr + i)] = d;
         send(d, 1'b1);
      end
      send(crc ^ {7'h00, bad}, 1'b1);
      host_u.stop();
      drain();
      chk(pec_err, bad);
      for (int i = 0; i < n; i++) chk(mem[16'(ptr + i)], exp_mem[16'(ptr + i)]);
      ptr += n;
   endtask
   task automatic blk_rd();
      open_tx();
      send(AW, 1'b1);
      send(8'hFD, 1'b1);
      host_u.start();
      send(AR, 1'b1);
      recv(1'b1, 8'h20);
      for (int i = 0; i < 32; i++) recv(1'b1, exp_mem[16'(ptr + i)]);
      recv(1'b0, crc);
      host_u.stop();
      ptr += 32;
   endtask
   // ---------------------------------
   // main sequence
   // ---------------------------------
   initial begin
      for (int i = 0; i < 65536; i++) begin
         mem[i] = 8'(i ^ 32'h5A);
         exp_mem[i] = 8'(i ^ 32'h5A);
      end
      repeat (20) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge core_clk);
      // ram: address first, then block write, block read, single read
      for (int t = 0; t < 3; t++) begin
         a = ($random(seed) & 32'hFF) % 32'hC0;
         set_addr(16'(a), 1'b0);
         blk_wr((t == 2) ? 32 : 1 + ($random(seed) & 31), t == 1);
         set_addr(16'(a), 1'b0);
         blk_rd();
         open_tx();
         send(AR, 1'b1);
         recv(1'b0, exp_mem[16'(ptr)]);
         host_u.stop();
      end
      // eeprom block stays below the top address, fresh locations only
      a = 32'hF800 | ($random(seed) & 32'h3C0);
      set_addr(16'(a), 1'b1);
      s0 = stretch;
      blk_wr(6, 1'b0);
      chk(stretch > s0, 1'b1);
      set_addr(16'(a), 1'b1);
      blk_rd();
      // foreign address is not acknowledged
      open_tx();
      send(AW ^ 8'h02, 1'b0);
      host_u.stop();
      // single ram write with check byte
      a = 32'hDF;
      exp_mem[a] = 8'hC3;
      open_tx();
      send(AW, 1'b1);
      send(8'hDF, 1'b1);
      send(8'hC3, 1'b1);
      send(crc, 1'b1);
      host_u.stop();
      drain();
      chk(mem[a], exp_mem[a]);
      chk(pec_err, 1'b0);
      end_sim();
   end
   initial begin
      repeat (100000) @(posedge core_clk);
      errors++;
      end_sim();
   end
endmodule // smbus_block_memory_access_tb_top
